// ### cpu_alu_branch_ops.sv
/*
 * Execution unit for the logic, multiply, cipher, indirect jump/call,
 * skip and conditional branch groups. Takes one decoded instruction
 * when ready, commits results at that edge, then stalls for the rest
 * of its cycle count. Assumes the front end supplies the next
 * instruction's length, the addressed I/O bit and the PC extension.
 */
// How it works
// RULE1 - set mask: OR immediate, flags ZNVS, one cycle
// RULE2 - clear mask: AND with FF minus K
// RULE3 - probe: AND with itself, set ZNVS
// RULE4 - products into R1:R0, Z and C, two cycles
// RULE5 - fractional products shifted left one bit
// RULE6 - cipher step: H selects encrypt or decrypt
// RULE7 - z jump: PC low from Z, high cleared
// RULE8 - ext z jump: PC high from extension
// RULE9 - z subcall: push return, clear upper PC
// RULE10 - ext z subcall: push, extension upper, three cycles
// RULE11 - equal skip: skip next when registers equal
// RULE12 - register bit skips on clear or set
// RULE13 - I/O bit skips, two to four cycles
// RULE14 - flag branches: PC plus k plus one
// RULE15 - signed branches use N xor V
// RULE16 - unsigned branches follow carry flag
// RULE17 - interrupt flag branches
// RULE18 - half carry and T flag branches
// RULE19 - overflow flag branches
// RULE20 - xor, invert and negate with flags
// RULE21 - untouched flags and registers keep values
`timescale 1ns/1ps
module cpu_alu_branch_ops
  import cpu_exec_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Decoded instruction
  input wire logic instValid,
  input wire instr_s instr,
  input wire logic nextTwoWord,
  input wire logic ioBitValue,
  input wire logic [5:0] pcExtension,
  // Preload of state
  input wire logic loadEn,
  input wire logic [4:0] loadAddr,
  input wire logic [7:0] loadData,
  input wire logic flagLoad,
  input wire logic [7:0] flagIn,
  input wire logic [4:0] peekAddr,
  // Status
  output logic ready,
  output logic done,
  output logic [PC_W-1:0] pc,
  output logic [7:0] flags,
  output logic [7:0] peekData,
  // Return address push
  output logic pushValid,
  output logic [PC_W-1:0] pushAddr
);

  state_e st_reg;
  logic [2:0] cnt_reg;
  logic prevCipher_reg;
  logic accept;
  logic [REGS_W-1:0] regs;
  logic [NUM_REGS-1:0] wrMask;
  logic [REGS_W-1:0] wrData;
  logic [7:0] rdv, rrv, logicRes, flags_next;
  logic [PC_W-1:0] pc_next, pcPlusOne, zTarget, relTarget, skipTarget;
  logic [15:0] zPtr, prodRes;
  logic [2:0] cycles;
  logic prodC, prodZ, isMul, isLogic, skipCond, brCond, brFlag;
  logic [63:0] ciphL, ciphR, ciphOutL, ciphOutR;
  logic [3:0] key;

  assign accept = instValid && ready;
  assign rdv = regs[instr.rd*8 +: 8];
  assign rrv = regs[instr.rr*8 +: 8];
  assign zPtr = {regs[Z_HI_ADDR*8 +: 8], regs[Z_LO_ADDR*8 +: 8]};
  assign pcPlusOne = pc + 22'h00_0001;

  reg_file u_regs (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wrMask(wrMask),
    .wrData(wrData),
    .regsOut(regs)
  );

  product_unit u_mul (
    .opA(rdv),
    .opB(rrv),
    .signedA(instr.op inside {OP_MUL_SS, OP_MUL_SU, OP_FRAC_PRODUCT_UU_SS,
                              OP_FRAC_PRODUCT_UU_SU}),
    .signedB(instr.op inside {OP_MUL_SS, OP_FRAC_PRODUCT_UU_SS}),
    .fractional(instr.op inside {OP_FRAC_PRODUCT_UU_UU, OP_FRAC_PRODUCT_UU_SS, OP_FRAC_PRODUCT_UU_SU}),
    .result(prodRes),
    .carryOut(prodC),
    .zeroOut(prodZ)
  );

  assign isMul = instr.op inside {OP_MUL_UU, OP_MUL_SS, OP_MUL_SU,
                                  OP_FRAC_PRODUCT_UU_UU, OP_FRAC_PRODUCT_UU_SS, OP_FRAC_PRODUCT_UU_SU};
  assign isLogic = instr.op inside {OP_XOR, OP_INVERT, OP_FLIP,
                                    OP_SETMASK, OP_CLRMASK, OP_PROBE};

  // Byte-wide logic results
  always_comb begin
    case (instr.op)
      OP_XOR: logicRes = rdv ^ rrv; // RULE20
      OP_INVERT: logicRes = ALL_ONES - rdv; // RULE20
      OP_FLIP: logicRes = 8'h00 - rdv; // RULE20
      OP_SETMASK: logicRes = rdv | instr.imm; // RULE1
      OP_CLRMASK: logicRes = rdv & (ALL_ONES - instr.imm); // RULE2
      OP_PROBE: logicRes = rdv & rdv; // RULE3
      default: logicRes = rdv;
    endcase
  end

  // One keyed Feistel round; decrypt undoes encrypt for the same key
  always_comb begin
    key = instr.imm[3:0];
    ciphL = regs[127:64];
    ciphR = regs[63:0];
    if (!flags[FLAG_H]) begin
      ciphOutL = ciphR; // RULE6
      ciphOutR = ciphL ^ {ciphR[55:0], ciphR[63:56]} ^ {16{key}};
    end else begin
      ciphOutL = ciphR ^ {ciphL[55:0], ciphL[63:56]} ^ {16{key}};
      ciphOutR = ciphL; // RULE6
    end
  end

  // Skip and branch conditions
  always_comb begin
    case (instr.op)
      OP_EQSKIP: skipCond = (rdv == rrv); // RULE11
      OP_RBCSKIP: skipCond = !rrv[instr.bitSel]; // RULE12
      OP_RBSSKIP: skipCond = rrv[instr.bitSel]; // RULE12
      OP_IOCSKIP: skipCond = !ioBitValue; // RULE13
      OP_IOSSKIP: skipCond = ioBitValue; // RULE13
      default: skipCond = 1'b0;
    endcase
    // Signed compares test N xor V directly, not the stored S
    if (instr.bitSel == 3'(FLAG_S)) begin
      brFlag = flags[FLAG_N] ^ flags[FLAG_V]; // RULE15
    end else begin
      // C, V, H, T and I branches read their own bit
      brFlag = flags[instr.bitSel]; // RULE16 RULE17 RULE18 RULE19
    end
    brCond = (instr.op == OP_FSETBR) ? brFlag : !brFlag; // RULE14
  end

  assign relTarget = pcPlusOne + {{10{instr.offset[11]}}, instr.offset};
  assign skipTarget = pc + (nextTwoWord ? 22'h00_0003 : 22'h00_0002);
  assign zTarget = {instr.op inside {OP_EZJMP, OP_EZCALL} ?
                    pcExtension : 6'h00, zPtr}; // RULE7 RULE8

  // Next PC
  always_comb begin
    case (instr.op)
      OP_ZJMP, OP_EZJMP, OP_ZCALL, OP_EZCALL:
        pc_next = zTarget; // RULE7 RULE8 RULE9 RULE10
      OP_EQSKIP, OP_RBCSKIP, OP_RBSSKIP, OP_IOCSKIP, OP_IOSSKIP:
        pc_next = skipCond ? skipTarget : pcPlusOne; // RULE11 RULE13
      OP_FSETBR, OP_FCLRBR:
        pc_next = brCond ? relTarget : pcPlusOne; // RULE14
      default:
        pc_next = pcPlusOne;
    endcase
  end

  // Cycle count of the accepted instruction
  always_comb begin
    cycles = CYC_LOGIC;
    case (instr.op)
      OP_CIPHER:
        cycles = prevCipher_reg ? CYC_CIPHER_NEXT : CYC_CIPHER_FIRST;
      OP_ZJMP, OP_EZJMP: cycles = CYC_JUMP; // RULE7 RULE8
      OP_ZCALL: cycles = CYC_ZCALL; // RULE9
      OP_EZCALL: cycles = CYC_EZCALL; // RULE10
      OP_EQSKIP, OP_RBCSKIP, OP_RBSSKIP, OP_IOCSKIP, OP_IOSSKIP:
        cycles = (instr.op inside {OP_IOCSKIP, OP_IOSSKIP} ? CYC_IOSKIP_BASE
                  : CYC_SKIP_BASE) + (skipCond ? (nextTwoWord ? 3'h2 : 3'h1)
                    : 3'h0); // RULE11 RULE12 RULE13
      default: begin
        if (isMul) begin
          cycles = CYC_MUL; // RULE4 RULE5
        end
      end
    endcase
  end

  // Flag updates; bits not named by an operation stay put
  always_comb begin
    flags_next = flags; // RULE21
    if (isLogic) begin
      flags_next[FLAG_Z] = (logicRes == 8'h00);
      flags_next[FLAG_N] = logicRes[7];
      flags_next[FLAG_V] = 1'b0; // RULE1 RULE2 RULE3 RULE20
      if (instr.op == OP_INVERT) begin
        flags_next[FLAG_C] = 1'b1; // RULE20
      end
      if (instr.op == OP_FLIP) begin
        flags_next[FLAG_C] = (logicRes != 8'h00);
        flags_next[FLAG_V] = (logicRes == SIGN_ONLY);
        flags_next[FLAG_H] = logicRes[3] | rdv[3]; // RULE20
      end
      flags_next[FLAG_S] = flags_next[FLAG_N] ^ flags_next[FLAG_V];
    end else if (isMul) begin
      flags_next[FLAG_Z] = prodZ; // RULE4 RULE5
      flags_next[FLAG_C] = prodC;
    end
  end

  // Register writes, only to the named destinations
  always_comb begin
    wrMask = '0; // RULE21
    wrData = regs;
    if (accept && isLogic && instr.op != OP_PROBE) begin
      wrMask[instr.rd] = 1'b1;
      wrData[instr.rd*8 +: 8] = logicRes;
    end else if (accept && isMul) begin
      wrMask[1:0] = 2'b11; // RULE4 RULE5
      wrData[15:0] = prodRes;
    end else if (accept && instr.op == OP_CIPHER) begin
      wrMask[15:0] = 16'hFFFF; // RULE6
      wrData[127:0] = {ciphOutL, ciphOutR};
    end else if (loadEn) begin
      wrMask[loadAddr] = 1'b1;
      wrData[loadAddr*8 +: 8] = loadData;
    end
  end

  // Stall sequencing
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      ready <= 1'b1;
      done <= 1'b0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          done <= accept && (cycles == 3'h1);
          if (accept && cycles > 3'h1) begin
            st_reg <= ST_BUSY;
            cnt_reg <= cycles - 3'h1;
            ready <= 1'b0;
          end
        end
        ST_BUSY: begin
          cnt_reg <= cnt_reg - 3'h1;
          done <= (cnt_reg == 3'h1);
          if (cnt_reg == 3'h1) begin
            st_reg <= ST_IDLE;
            ready <= 1'b1;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
          ready <= 1'b1;
          done <= 1'b0;
        end
      endcase
    end
  end

  // Architectural state commits at the accepting edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc <= PC_RESET;
      flags <= FLAGS_RESET;
      prevCipher_reg <= 1'b0;
    end else if (accept) begin
      pc <= pc_next;
      flags <= flags_next;
      prevCipher_reg <= (instr.op == OP_CIPHER);
    end else if (flagLoad) begin
      flags <= flagIn;
    end
  end

  // Return address for the subcalls
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pushValid <= 1'b0;
      pushAddr <= PC_RESET;
    end else begin
      pushValid <= accept && instr.op inside {OP_ZCALL, OP_EZCALL};
      if (accept) begin
        pushAddr <= pcPlusOne; // RULE9 RULE10
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      peekData <= 8'h00;
    end else begin
      peekData <= regs[peekAddr*8 +: 8];
    end
  end

  // Checks
  sequence s_accOp(op_e o);
    accept && instr.op == o;
  endsequence

  property p_setmask;
    @(posedge sys_clk) disable iff (sys_rst)
    s_accOp(OP_SETMASK) |=> done && !flags[FLAG_V];
  endproperty
  a_setmask: assert property (p_setmask) // RULE1
    else $error("set mask not single cycle");
  property p_clrmask;
    logic [7:0] exp;
    @(posedge sys_clk) disable iff (sys_rst)
    (s_accOp(OP_CLRMASK), exp = rdv & ~instr.imm)
      |=> regs[$past(instr.rd)*8 +: 8] == exp;
  endproperty
  a_clrmask: assert property (p_clrmask) // RULE2
    else $error("clear mask result wrong");
  property p_probe;
    @(posedge sys_clk) disable iff (sys_rst)
    s_accOp(OP_PROBE) |=> $stable(regs) &&
      flags[FLAG_Z] == ($past(rdv) == 8'h00);
  endproperty
  a_probe: assert property (p_probe) // RULE3
    else $error("probe changed register or bad Z");
  property p_mul;
    @(posedge sys_clk) disable iff (sys_rst)
    accept && isMul |=> !ready ##1 ready && done;
  endproperty
  a_mul: assert property (p_mul) // RULE4
    else $error("multiply not two cycles");
  property p_mulval;
    @(posedge sys_clk) disable iff (sys_rst)
    s_accOp(OP_MUL_UU) |=> regs[15:0] == $past(rdv) * $past(rrv);
  endproperty
  a_mulval: assert property (p_mulval) // RULE4
    else $error("unsigned product wrong");
  property p_zjmp;
    @(posedge sys_clk) disable iff (sys_rst)
    s_accOp(OP_ZJMP) |=> pc[21:16] == 6'h00 && pc[15:0] == $past(zPtr)
      ##1 ready;
  endproperty
  a_zjmp: assert property (p_zjmp) // RULE7
    else $error("z jump target or timing wrong");
  property p_ezcall;
    @(posedge sys_clk) disable iff (sys_rst)
    s_accOp(OP_EZCALL) |=> pushValid && pc[21:16] == $past(pcExtension)
      ##0 !ready [*2] ##1 ready;
  endproperty
  a_ezcall: assert property (p_ezcall) // RULE10
    else $error("ext subcall wrong");
  property p_branch;
    @(posedge sys_clk) disable iff (sys_rst)
    accept && instr.op inside {OP_FSETBR, OP_FCLRBR} && brCond
      |=> pc == $past(relTarget) && $stable(flags);
  endproperty
  a_branch: assert property (p_branch) // RULE14
    else $error("taken branch target wrong");
  property p_eqskip;
    @(posedge sys_clk) disable iff (sys_rst)
    s_accOp(OP_EQSKIP) ##0 (rdv != rrv) |=> pc == $past(pcPlusOne) && done;
  endproperty
  a_eqskip: assert property (p_eqskip) // RULE11
    else $error("untaken skip wrong");

endmodule : cpu_alu_branch_ops

// ### cpu_exec_pkg.sv
/*
 * Shared types and constants for the execution unit: operation codes,
 * the decoded instruction carrier, flag positions and cycle counts.
 * Assumes a front end that decodes opcodes into instr_s.
 */
package cpu_exec_pkg;

  localparam int PC_W = 22;
  localparam int NUM_REGS = 32;
  localparam int REGS_W = NUM_REGS * 8;

  // Flag positions inside the flag_register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 22'h00_0000;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] SIGN_ONLY = 8'h80;

  // Register addresses of the Z pointer (R31:R30)
  localparam logic [4:0] Z_LO_ADDR = 5'h1E;
  localparam logic [4:0] Z_HI_ADDR = 5'h1F;

  // Cycle counts
  localparam logic [2:0] CYC_LOGIC = 3'h1;
  localparam logic [2:0] CYC_MUL = 3'h2;
  localparam logic [2:0] CYC_CIPHER_FIRST = 3'h2;
  localparam logic [2:0] CYC_CIPHER_NEXT = 3'h1;
  localparam logic [2:0] CYC_JUMP = 3'h2;
  localparam logic [2:0] CYC_ZCALL = 3'h3;
  localparam logic [2:0] CYC_EZCALL = 3'h3;
  localparam logic [2:0] CYC_SKIP_BASE = 3'h1;
  localparam logic [2:0] CYC_IOSKIP_BASE = 3'h2;
  localparam logic [2:0] CYC_BR_BASE = 3'h1;

  typedef enum logic [4:0] {
    OP_XOR = 5'h00, OP_INVERT = 5'h01, OP_FLIP = 5'h02,
    OP_SETMASK = 5'h03, OP_CLRMASK = 5'h04, OP_PROBE = 5'h05,
    OP_MUL_UU = 5'h06, OP_MUL_SS = 5'h07, OP_MUL_SU = 5'h08,
    OP_FRAC_PRODUCT_UU_UU = 5'h09, OP_FRAC_PRODUCT_UU_SS = 5'h0A, OP_FRAC_PRODUCT_UU_SU = 5'h0B,
    OP_CIPHER = 5'h0C, OP_ZJMP = 5'h0D, OP_EZJMP = 5'h0E,
    OP_ZCALL = 5'h0F, OP_EZCALL = 5'h10, OP_EQSKIP = 5'h11,
    OP_RBCSKIP = 5'h12, OP_RBSSKIP = 5'h13, OP_IOCSKIP = 5'h14,
    OP_IOSSKIP = 5'h15, OP_FSETBR = 5'h16, OP_FCLRBR = 5'h17
  } op_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } state_e;

  typedef struct packed {
    op_e op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [7:0] imm;
    logic [2:0] bitSel;
    logic [11:0] offset;
  } instr_s;

endpackage : cpu_exec_pkg

// ### product_unit.sv
/*
 * 8x8 multiplier with per-operand signedness and optional fractional
 * shift. Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module product_unit
  import cpu_exec_pkg::*;
(
  // Operands
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  // Mode
  input wire logic signedA,
  input wire logic signedB,
  input wire logic fractional,
  // Result
  output logic [15:0] result,
  output logic carryOut,
  output logic zeroOut
);

  logic signed [17:0] wideProd;
  logic [15:0] rawProd;

  always_comb begin
    wideProd = $signed({signedA & opA[7], opA}) *
               $signed({signedB & opB[7], opB});
    rawProd = wideProd[15:0];
    // Carry is the product's top bit before the fractional shift
    carryOut = rawProd[15];
    result = fractional ? {rawProd[14:0], 1'b0} : rawProd;
    zeroOut = (result == 16'h0000);
  end

endmodule : product_unit

// ### reg_file.sv
/*
 * General register file, 32 bytes, held in flip-flops and exposed as
 * one flat vector so the cipher step can see R15..R0 at once.
 * A byte mask selects which registers take the write data.
 */
`timescale 1ns/1ps
module reg_file
  import cpu_exec_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Write
  input wire logic [NUM_REGS-1:0] wrMask,
  input wire logic [REGS_W-1:0] wrData,
  // Contents
  output logic [REGS_W-1:0] regsOut
);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regsOut <= '0;
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (wrMask[i]) begin
          regsOut[i*8 +: 8] <= wrData[i*8 +: 8];
        end
      end
    end
  end

endmodule : reg_file

// ### prog_io_model.sv
/*
 * Far-side model: program memory layout, I/O space bits and the
 * upper_pc_extension register as seen by the execution unit.
 * Assumes the bench wires pc and the I/O select from the instruction.
 */
`timescale 1ns/1ps
module prog_io_model
  import cpu_exec_pkg::*;
#(
  parameter logic [5:0] EXT_VAL = 6'h2A
)
(
  // Program counter and I/O select
  input wire logic [PC_W-1:0] pc,
  input wire logic [5:0] ioAddr,
  input wire logic [2:0] ioBit,
  // Answers
  output logic nextTwoWord,
  output logic ioBitValue,
  output logic [5:0] pcExtension
);
  logic [7:0] ioMem [64];

  initial begin
    for (int i = 0; i < 64; i++) begin
      ioMem[i] = 8'(i * 37);
    end
  end

  // The instruction after an even program address is two words long
  assign nextTwoWord = ~pc[0];
  assign ioBitValue = ioMem[ioAddr][ioBit];
  assign pcExtension = EXT_VAL;
endmodule : prog_io_model

// ### cpu_alu_branch_ops_tb_top.sv
/*
 * Self-checking bench for cpu_alu_branch_ops: logic, multiply, cipher,
 * jump, skip and branch sequences against computed expectations.
 * Assumes prog_io_model answers the I/O and program-memory inputs.
 */
`timescale 1ns/1ps
module cpu_alu_branch_ops_tb_top
  import cpu_exec_pkg::*;
;
  localparam logic [5:0] EXT_VAL = 6'h2A;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instValid = 1'b0;
  logic loadEn = 1'b0;
  logic flagLoad = 1'b0;
  instr_s instr = '0;
  logic [4:0] loadAddr = '0;
  logic [4:0] peekAddr = '0;
  logic [7:0] loadData = '0;
  logic [7:0] flagIn = '0;
  logic nextTwoWord, ioBitValue, ready, done, pushValid, pushSeen;
  logic [5:0] pcExtension;
  logic [PC_W-1:0] pc, pushAddr, pushAt, expPc, ret;
  logic [7:0] flags, peekData, expFlags, v, a, ioB;
  logic [15:0] r;
  logic [16:0] m;
  logic [11:0] off;
  logic c, f, bitv;
  int num_errors = 0;
  int checks = 0;
  int cycCount = 0;
  int n, k, opI, skip;
  op_e lops [6] = '{OP_XOR, OP_INVERT, OP_FLIP, OP_SETMASK, OP_CLRMASK,
    OP_PROBE};
  op_e mops [6] = '{OP_MUL_UU, OP_MUL_SS, OP_MUL_SU, OP_FRAC_PRODUCT_UU_UU,
    OP_FRAC_PRODUCT_UU_SS, OP_FRAC_PRODUCT_UU_SU};
  op_e jops [4] = '{OP_ZJMP, OP_EZJMP, OP_ZCALL, OP_EZCALL};
  op_e sops [5] = '{OP_EQSKIP, OP_RBCSKIP, OP_RBSSKIP, OP_IOCSKIP,
    OP_IOSSKIP};

  always #5 sys_clk = ~sys_clk;

  cpu_alu_branch_ops dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .instValid(instValid), .instr(instr), .nextTwoWord(nextTwoWord),
    .ioBitValue(ioBitValue), .pcExtension(pcExtension), .loadEn(loadEn),
    .loadAddr(loadAddr), .loadData(loadData), .flagLoad(flagLoad),
    .flagIn(flagIn), .peekAddr(peekAddr), .ready(ready), .done(done),
    .pc(pc), .flags(flags), .peekData(peekData), .pushValid(pushValid),
    .pushAddr(pushAddr));

  prog_io_model #(.EXT_VAL(EXT_VAL)) far (.pc(pc), .ioAddr(instr.imm[5:0]),
    .ioBit(instr.bitSel), .nextTwoWord(nextTwoWord),
    .ioBitValue(ioBitValue), .pcExtension(pcExtension));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [21:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chkCyc(input string nm, input int e, g);
    checks++;
    if (e != g) begin
      num_errors++;
      $display("mismatch %s cycles expected %0d seen %0d", nm, e, g);
    end
  endtask : chkCyc

  task automatic preload(input logic fl, input logic [4:0] ad,
    input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    flagLoad = fl;
    loadEn = ~fl;
    loadAddr = ad;
    loadData = d;
    flagIn = d;
    if (fl)
      expFlags = d;
    @(posedge sys_clk);
    #1;
    flagLoad = 1'b0;
    loadEn = 1'b0;
  endtask : preload

  task automatic peek(input logic [4:0] ad);
    @(posedge sys_clk);
    #1;
    peekAddr = ad;
    @(posedge sys_clk);
    #1;
    v = peekData;
  endtask : peek

  task automatic chkReg(input logic [4:0] ad, input logic [7:0] e);
    peek(ad);
    chk("register", 22'(e), 22'(v));
  endtask : chkReg

  // Result commits at the taking edge; done marks the last cycle
  task automatic run(input op_e op, input logic [4:0] rd, rr,
    input logic [7:0] imm, input logic [2:0] b, input logic [11:0] o,
    input int expCyc);
    int cn;
    @(posedge sys_clk);
    #1;
    instr = '{op, rd, rr, imm, b, o};
    instValid = 1'b1;
    @(posedge sys_clk);
    #1;
    instValid = 1'b0;
    pushSeen = pushValid;
    pushAt = pushAddr;
    chk("ready after take", 22'(expCyc == 1), 22'(ready));
    cn = 1;
    while (done !== 1'b1 && cn < 8) begin
      @(posedge sys_clk);
      #1;
      cn++;
    end
    chkCyc(op.name(), expCyc, cn);
    chk("ready at end", 22'h1, 22'(ready));
    chk("pc", expPc, pc);
    chk("flags", 22'(expFlags), 22'(flags));
  endtask : run

  function automatic logic [15:0] logicExp(input op_e op,
    input logic [7:0] x, y, fl);
    logic [7:0] q;
    case (op)
      OP_XOR: q = x ^ y;
      OP_INVERT: q = 8'hFF - x;
      OP_FLIP: q = 8'h00 - x;
      OP_SETMASK: q = x | y;
      OP_CLRMASK: q = x & (8'hFF - y);
      default: q = x & x;
    endcase
    fl[FLAG_Z] = (q == 8'h00);
    fl[FLAG_N] = q[7];
    fl[FLAG_V] = (op == OP_FLIP) && (q == 8'h80);
    if (op == OP_INVERT)
      fl[FLAG_C] = 1'b1;
    if (op == OP_FLIP) begin
      fl[FLAG_C] = (q != 8'h00);
      fl[FLAG_H] = q[3] | x[3];
    end
    fl[FLAG_S] = fl[FLAG_N] ^ fl[FLAG_V];
    return {q, fl};
  endfunction : logicExp

  function automatic logic [16:0] mulExp(input int i, input logic [7:0] x, y);
    logic signed [17:0] p;
    p = $signed({i % 3 != 0 && x[7], x}) * $signed({i % 3 == 1 && y[7], y});
    return {p[15], (i > 2) ? {p[14:0], 1'b0} : p[15:0]};
  endfunction : mulExp

  always @(posedge sys_clk) begin
    cycCount++;
    if (cycCount == 10000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    expPc = PC_RESET;
    expFlags = FLAGS_RESET;
    chk("reset flags", 22'(FLAGS_RESET), 22'(flags));
    for (int i = 0; i < 12; i++) begin
      a = (i > 5) ? 8'h80 : 8'h5A;
      preload(1'b0, 5'h10, a);
      preload(1'b0, 5'h11, 8'h5A);
      preload(1'b1, 5'h00, (i > 5) ? 8'h1E : 8'hE1);
      r = logicExp(lops[i % 6], a, 8'h5A, expFlags);
      expFlags = r[7:0];
      expPc = expPc + 22'h1;
      run(lops[i % 6], 5'h10, 5'h11, 8'h5A, 3'h0, 12'h000, 1);
      chkReg(5'h10, r[15:8]);
      chkReg(5'h11, 8'h5A);
    end
    $display("test logic done");
    for (int i = 0; i < 12; i++) begin
      preload(1'b0, 5'h10, 8'hFE);
      preload(1'b0, 5'h11, (i > 5) ? 8'h00 : 8'h83);
      preload(1'b1, 5'h00, 8'hFC);
      m = mulExp(i % 6, 8'hFE, (i > 5) ? 8'h00 : 8'h83);
      expFlags[FLAG_C] = m[16];
      expFlags[FLAG_Z] = (m[15:0] == 16'h0000);
      expPc = expPc + 22'h1;
      run(mops[i % 6], 5'h10, 5'h11, 8'h00, 3'h0, 12'h000, 2);
      chkReg(5'h00, m[7:0]);
      chkReg(5'h01, m[15:8]);
      chkReg(5'h10, 8'hFE);
    end
    $display("test multiply done");
    for (int i = 0; i < 16; i++) begin
      preload(1'b0, 5'(i), 8'(i * 17 + 3));
    end
    preload(1'b1, 5'h00, 8'h00);
    expPc = expPc + 22'h1;
    run(OP_CIPHER, 5'h00, 5'h00, 8'h05, 3'h0, 12'h000, 2);
    n = 0;
    // Encrypt round moves the old low half into the high half
    for (int i = 0; i < 16; i++) begin
      peek(5'(i));
      if (i > 7)
        chk("cipher left half", 22'(8'((i - 8) * 17 + 3)), 22'(v));
      else
        n += int'(v !== 8'(i * 17 + 3));
    end
    chk("cipher changed data", 22'h1, 22'(n > 0));
    preload(1'b1, 5'h00, 8'h20);
    expPc = expPc + 22'h1;
    run(OP_CIPHER, 5'h00, 5'h00, 8'h05, 3'h0, 12'h000, 1);
    for (int i = 0; i < 16; i++) begin
      chkReg(5'(i), 8'(i * 17 + 3));
    end
    $display("test cipher done");
    for (int i = 0; i < 4; i++) begin
      preload(1'b0, Z_LO_ADDR, 8'(i * 16 + 4));
      preload(1'b0, Z_HI_ADDR, 8'h12);
      ret = expPc + 22'h1;
      expPc = {(i % 2 == 1) ? EXT_VAL : 6'h00, 8'h12, 8'(i * 16 + 4)};
      run(jops[i], 5'h00, 5'h00, 8'h00, 3'h0, 12'h000,
        (i > 1) ? 3 : 2);
      chk("push valid", 22'(i > 1), 22'(pushSeen));
      if (i > 1)
        chk("return address", ret, pushAt);
    end
    $display("test jump done");
    preload(1'b0, 5'h10, 8'hA5);
    for (int i = 0; i < 20; i++) begin
      k = i % 4;
      opI = i / 4;
      preload(1'b0, 5'h11, k[0] ? 8'hA5 : 8'h5A);
      ioB = 8'((k + 4) * 37);
      bitv = (opI > 2) ? ioB[k] : a5Bit(k);
      c = (opI == 0) ? k[0] : (opI[0] ? ~bitv : bitv);
      skip = c ? (expPc[0] ? 1 : 2) : 0;
      expPc = expPc + 22'(1 + skip);
      run(sops[opI], 5'h10, (opI == 0) ? 5'h11 : 5'h10, 8'(k + 4), 3'(k),
        12'h000, ((opI > 2) ? 2 : 1) + skip);
    end
    $display("test skip done");
    for (int i = 0; i < 32; i++) begin
      preload(1'b1, 5'h00, i[4] ? 8'hA5 : 8'h5A);
      off = i[0] ? 12'hFFD : 12'h005;
      f = (i % 8 == 4) ? expFlags[FLAG_N] ^ expFlags[FLAG_V] : expFlags[i % 8];
      c = i[3] ? ~f : f;
      expPc = expPc + 22'h1 + (c ? {{10{off[11]}}, off} : 22'h00_0000);
      run(i[3] ? OP_FCLRBR : OP_FSETBR, 5'h00, 5'h00, 8'h00, 3'(i), off,
        1);
    end
    $display("test branch done");
    end_of_test();
  end

  function automatic logic a5Bit(input int b);
    logic [7:0] pat;
    pat = 8'hA5;
    return pat[b];
  endfunction : a5Bit
endmodule : cpu_alu_branch_ops_tb_top
